// ==== include/bqs_pkg.sv ====
// shared constants and state types for the burst-of-two split-port memory
package bqs_pkg;

  // array geometry
  localparam int ADDR_W = 19;
  localparam int WORD_W = 18;
  localparam int BURST_LEN = 2;

  // byte lane field positions inside one word
  localparam int LANE0_LSB = 0;
  localparam int LANE0_MSB = 8;
  localparam int LANE1_LSB = 9;
  localparam int LANE1_MSB = 17;

  // values after reset
  localparam logic [WORD_W-1:0] RD_DATA_RST = 18'h00000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [1:0] MASK_RST = 2'h3;

  // read launch sequence, gray coded along idle -> first -> second
  typedef enum logic [1:0] {
    BQS_RD_IDLE = 2'h0,
    BQS_RD_BEAT0 = 2'h1,
    BQS_RD_BEAT1 = 2'h3
  } bqs_rd_state_t;

  // write capture sequence
  typedef enum logic {
    BQS_WR_IDLE = 1'h0,
    BQS_WR_BEAT0 = 1'h1
  } bqs_wr_state_t;

endpackage

// ==== include/bqs_edge_if.sv ====
// carrier for one detected clock-pin rising edge
`timescale 1ns/1ps
interface bqs_edge_if;
  logic rise; // one-cycle pulse on a pin rising edge

  modport src (output rise);
  modport dst (input rise);
endinterface

// ==== hw/bqs_edge.sv ====
// registers one clock pin and flags its rising edges
`timescale 1ns/1ps
module bqs_edge (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic pin, // clock pin, sampled as synchronous level
  bqs_edge_if.src edge_o // rising edge pulse
);

  logic pin_q;
  logic pin_d;
  logic prev_q;
  logic prev_d;

  // next values: present sample and the one before it
  always_comb begin
    pin_d = pin;
    prev_d = pin_q;
  end

  // sample history, cleared low, so a pin already high at release counts as one rising edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      prev_q <= prev_d;
    end
  end

  // only a low to high step counts; the falling step is ignored
  assign edge_o.rise = pin_q & ~prev_q;

endmodule // bqs_edge

// ==== hw/bqs_sram.sv ====
// burst-of-two split-port pipelined static memory, device side
`timescale 1ns/1ps
// Summary of operation
// - read address is taken from the address lines on a positive input clock rise.
// - write address is taken from the address lines on a complementary clock rise.
// - every read or write starts at a positive input clock rise.
// - read and write ports run independently and may overlap.
// - write data beats are taken on both input clock rises.
// - read data beats leave on both output clock rises.
// - single clock mode launches read data on the input clock pair instead.
// - each address holds two 18-bit words moved as a burst of two.
// - each port has its own active-low select.
// - every synchronous input except single_clk_mode is registered before internal use.
// - read data leaves through an output register.
// - writes complete internally with no extra strobes.
// - separate one-way input and output data buses, no turnaround.
// - only rising clock edges have any effect.
// - one shared address bus carries both read and write addresses.
// - write select low at positive rise starts a write; otherwise data ignored.
// - read deselect lets a pending read finish, then outputs float next rise.
// - two active-low lane masks gate bits 8:0 and 17:9 per beat.
// - address bus is 19 bits and picks one burst-pair location.
module bqs_sram #(
  parameter int ADDR_W = bqs_pkg::ADDR_W, // address bus width
  parameter int WORD_W = bqs_pkg::WORD_W // data word width
) (
  input wire logic core_clk, // core clock, 250 MHz
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic k_clk, // positive input clock pin
  input wire logic k_clk_n, // complementary input clock pin
  input wire logic c_clk, // positive output clock pin
  input wire logic c_clk_n, // complementary output clock pin
  input wire logic single_clk_mode, // high: launch reads on the input clock pair
  input wire logic [ADDR_W-1:0] addr, // shared read and write address
  input wire logic [WORD_W-1:0] wr_data, // write data beat
  input wire logic lane_wr_mask_0, // active low, gates bits 8:0
  input wire logic lane_wr_mask_1, // active low, gates bits 17:9
  input wire logic wr_port_sel_n, // write port select, active low
  input wire logic rd_port_sel_n, // read port select, active low
  output logic [WORD_W-1:0] rd_data, // read data beat, registered
  output logic rd_data_oe // read data drive enable, registered
);

  localparam int DEPTH = (2 ** ADDR_W) * bqs_pkg::BURST_LEN;

  //////////////////////////////////////////////////////////////////////////////
  // clock pin edge detection

  bqs_edge_if k_if ();
  bqs_edge_if kn_if ();
  bqs_edge_if c_if ();
  bqs_edge_if cn_if ();

  bqs_edge u_k_edge (.core_clk(core_clk), .arst_n(arst_n), .pin(k_clk), .edge_o(k_if));
  bqs_edge u_kn_edge (.core_clk(core_clk), .arst_n(arst_n), .pin(k_clk_n), .edge_o(kn_if));
  bqs_edge u_c_edge (.core_clk(core_clk), .arst_n(arst_n), .pin(c_clk), .edge_o(c_if));
  bqs_edge u_cn_edge (.core_clk(core_clk), .arst_n(arst_n), .pin(c_clk_n), .edge_o(cn_if));

  logic k_rise;
  logic kn_rise;
  logic out_rise;
  logic out_fall;

  // output launch edges come from the input pair in single clock mode
  assign k_rise = k_if.rise;
  assign kn_rise = kn_if.rise;
  assign out_rise = single_clk_mode ? k_rise : c_if.rise;
  assign out_fall = single_clk_mode ? kn_rise : cn_if.rise;

  //////////////////////////////////////////////////////////////////////////////
  // input registers, aligned with the registered clock samples

  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [WORD_W-1:0] din_q;
  logic [WORD_W-1:0] din_d;
  logic [1:0] mask_n_q;
  logic [1:0] mask_n_d;
  logic wsel_n_q;
  logic wsel_n_d;
  logic rsel_n_q;
  logic rsel_n_d;

  // every pin except single_clk_mode is sampled once before the core looks at it
  always_comb begin
    addr_d = addr;
    din_d = wr_data;
    mask_n_d = {lane_wr_mask_1, lane_wr_mask_0};
    wsel_n_d = wr_port_sel_n;
    rsel_n_d = rd_port_sel_n;
  end

  // selects reset deasserted so nothing starts before the first real sample
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= bqs_pkg::ADDR_RST;
      din_q <= bqs_pkg::RD_DATA_RST;
      mask_n_q <= bqs_pkg::MASK_RST;
      wsel_n_q <= 1'b1;
      rsel_n_q <= 1'b1;
    end else begin
      addr_q <= addr_d;
      din_q <= din_d;
      mask_n_q <= mask_n_d;
      wsel_n_q <= wsel_n_d;
      rsel_n_q <= rsel_n_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage: two words per address, low index bit picks the burst beat

  logic [WORD_W-1:0] mem [0:DEPTH-1];

  //////////////////////////////////////////////////////////////////////////////
  // write port

  bqs_pkg::bqs_wr_state_t wr_st_q;
  bqs_pkg::bqs_wr_state_t wr_st_d;
  logic [WORD_W-1:0] wbeat0_q;
  logic [WORD_W-1:0] wbeat0_d;
  logic [1:0] wmask0_q;
  logic [1:0] wmask0_d;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] wr_addr_d;
  logic wr_commit;

  // first beat with the start on a positive rise, address and second beat on the complement
  always_comb begin
    wr_st_d = wr_st_q;
    wbeat0_d = wbeat0_q;
    wmask0_d = wmask0_q;
    wr_addr_d = wr_addr_q;
    wr_commit = 1'b0;
    unique case (wr_st_q)
      bqs_pkg::BQS_WR_IDLE: begin
        if (k_rise && !wsel_n_q) begin
          wr_st_d = bqs_pkg::BQS_WR_BEAT0;
          wbeat0_d = din_q;
          wmask0_d = mask_n_q;
        end
      end
      bqs_pkg::BQS_WR_BEAT0: begin
        if (kn_rise) begin
          wr_addr_d = addr_q;
          wr_commit = 1'b1;
          wr_st_d = bqs_pkg::BQS_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_st_q <= bqs_pkg::BQS_WR_IDLE;
      wbeat0_q <= bqs_pkg::RD_DATA_RST;
      wmask0_q <= bqs_pkg::MASK_RST;
      wr_addr_q <= bqs_pkg::ADDR_RST;
    end else begin
      wr_st_q <= wr_st_d;
      wbeat0_q <= wbeat0_d;
      wmask0_q <= wmask0_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // self-timed commit of both beats; masked lanes keep their old contents
  always_ff @(posedge core_clk) begin
    if (wr_commit) begin
      if (!wmask0_q[0]) begin
        mem[{addr_q, 1'b0}][bqs_pkg::LANE0_MSB:bqs_pkg::LANE0_LSB] <=
          wbeat0_q[bqs_pkg::LANE0_MSB:bqs_pkg::LANE0_LSB];
      end
      if (!wmask0_q[1]) begin
        mem[{addr_q, 1'b0}][bqs_pkg::LANE1_MSB:bqs_pkg::LANE1_LSB] <=
          wbeat0_q[bqs_pkg::LANE1_MSB:bqs_pkg::LANE1_LSB];
      end
      if (!mask_n_q[0]) begin
        mem[{addr_q, 1'b1}][bqs_pkg::LANE0_MSB:bqs_pkg::LANE0_LSB] <=
          din_q[bqs_pkg::LANE0_MSB:bqs_pkg::LANE0_LSB];
      end
      if (!mask_n_q[1]) begin
        mem[{addr_q, 1'b1}][bqs_pkg::LANE1_MSB:bqs_pkg::LANE1_LSB] <=
          din_q[bqs_pkg::LANE1_MSB:bqs_pkg::LANE1_LSB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port, independent of the write sequence above

  bqs_pkg::bqs_rd_state_t rd_st_q;
  bqs_pkg::bqs_rd_state_t rd_st_d;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] rd_addr_d;
  logic [WORD_W-1:0] rbuf0_q;
  logic [WORD_W-1:0] rbuf0_d;
  logic [WORD_W-1:0] rbuf1_q;
  logic [WORD_W-1:0] rbuf1_d;
  logic [WORD_W-1:0] rsec_q;
  logic [WORD_W-1:0] rsec_d;
  logic pend_q;
  logic pend_d;
  logic [WORD_W-1:0] rd_data_d;
  logic rd_data_oe_d;
  logic rd_load;

  // a fetched burst waits in the buffer until the next output launch edge;
  // the buffer is one deep, so a launch and a new fetch may share a cycle
  always_comb begin
    rd_st_d = rd_st_q;
    rd_addr_d = rd_addr_q;
    rbuf0_d = rbuf0_q;
    rbuf1_d = rbuf1_q;
    rsec_d = rsec_q;
    pend_d = pend_q;
    rd_data_d = rd_data;
    rd_data_oe_d = rd_data_oe;
    rd_load = k_rise && !rsel_n_q;
    if (out_rise && pend_q) begin
      rd_data_d = rbuf0_q;
      rsec_d = rbuf1_q;
      rd_data_oe_d = 1'b1;
      pend_d = 1'b0;
      rd_st_d = bqs_pkg::BQS_RD_BEAT0;
    end else begin
      unique case (rd_st_q)
        bqs_pkg::BQS_RD_IDLE: begin
          rd_data_oe_d = 1'b0;
        end
        bqs_pkg::BQS_RD_BEAT0: begin
          if (out_fall) begin
            rd_data_d = rsec_q;
            rd_st_d = bqs_pkg::BQS_RD_BEAT1;
          end
        end
        bqs_pkg::BQS_RD_BEAT1: begin
          // deselected: the burst has finished, float after this positive rise
          if (k_rise && !pend_q && !rd_load) begin
            rd_data_oe_d = 1'b0;
            rd_st_d = bqs_pkg::BQS_RD_IDLE;
          end
        end
        default: begin
          rd_data_oe_d = 1'b0;
          rd_st_d = bqs_pkg::BQS_RD_IDLE;
        end
      endcase
    end
    if (rd_load) begin
      rd_addr_d = addr_q;
      rbuf0_d = mem[{addr_q, 1'b0}];
      rbuf1_d = mem[{addr_q, 1'b1}];
      pend_d = 1'b1;
    end
  end

  // data out only ever changes here, so the output bus needs no turnaround
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_st_q <= bqs_pkg::BQS_RD_IDLE;
      rd_addr_q <= bqs_pkg::ADDR_RST;
      rbuf0_q <= bqs_pkg::RD_DATA_RST;
      rbuf1_q <= bqs_pkg::RD_DATA_RST;
      rsec_q <= bqs_pkg::RD_DATA_RST;
      pend_q <= 1'b0;
      rd_data <= bqs_pkg::RD_DATA_RST;
      rd_data_oe <= 1'b0;
    end else begin
      rd_st_q <= rd_st_d;
      rd_addr_q <= rd_addr_d;
      rbuf0_q <= rbuf0_d;
      rbuf1_q <= rbuf1_d;
      rsec_q <= rsec_d;
      pend_q <= pend_d;
      rd_data <= rd_data_d;
      rd_data_oe <= rd_data_oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_rd_start;
    k_rise && !rsel_n_q;
  endsequence

  sequence s_launch0;
    out_rise && pend_q;
  endsequence

  a_rd_addr_capture: assert property (
    s_rd_start |=> (rd_addr_q == $past(addr_q)) && pend_q)
    else $error("read address not taken on positive rise");

  a_wr_addr_capture: assert property (
    (wr_st_q == bqs_pkg::BQS_WR_BEAT0 && kn_rise) |=>
      (wr_addr_q == $past(addr_q)) && (wr_st_q == bqs_pkg::BQS_WR_IDLE))
    else $error("write address not taken on complementary rise");

  a_wr_select_gate: assert property (
    (wr_st_q == bqs_pkg::BQS_WR_IDLE && !(k_rise && !wsel_n_q)) |=>
      (wr_st_q == bqs_pkg::BQS_WR_IDLE))
    else $error("write started without select");

  a_wr_start_beat: assert property (
    (wr_st_q == bqs_pkg::BQS_WR_IDLE && k_rise && !wsel_n_q) |=>
      (wr_st_q == bqs_pkg::BQS_WR_BEAT0) && (wbeat0_q == $past(din_q)))
    else $error("first write beat not captured");

  a_rd_beat0_out: assert property (
    s_launch0 |=> rd_data_oe && (rd_data == $past(rbuf0_q))
      && (rd_st_q == bqs_pkg::BQS_RD_BEAT0))
    else $error("first read beat not launched");

  a_rd_beat1_out: assert property (
    (rd_st_q == bqs_pkg::BQS_RD_BEAT0 && out_fall && !(out_rise && pend_q)) |=>
      (rd_data == $past(rsec_q)) && (rd_st_q == bqs_pkg::BQS_RD_BEAT1))
    else $error("second read beat not launched");

  a_single_clk_launch: assert property (
    (single_clk_mode && pend_q && k_rise) |=> rd_st_q == bqs_pkg::BQS_RD_BEAT0)
    else $error("single clock mode did not launch on input clock");

  a_rd_float_after: assert property (
    (rd_st_q == bqs_pkg::BQS_RD_BEAT1 && k_rise && !pend_q && rsel_n_q
      && !out_rise) |=> !rd_data_oe)
    else $error("outputs still driven after deselect");

  a_rise_only_addr: assert property (
    !k_rise |=> $stable(rd_addr_q))
    else $error("read address changed without positive rise");

  a_out_stable: assert property (
    (!out_rise && !out_fall && rd_st_q != bqs_pkg::BQS_RD_IDLE) |=> $stable(rd_data))
    else $error("read data changed without launch edge");

endmodule // bqs_sram

// ==== verif/bqs_ctrl_model.sv ====
// memory controller model driving the pin side of the burst memory
`timescale 1ns/1ps
module bqs_ctrl_model (
  input wire logic core_clk, // core clock
  output logic k_clk, // positive input clock pin
  output logic k_clk_n, // complementary input clock pin
  output logic c_clk, // positive output clock pin
  output logic c_clk_n, // complementary output clock pin
  output logic [bqs_pkg::ADDR_W-1:0] addr, // shared address
  output logic [bqs_pkg::WORD_W-1:0] wr_data, // write data beat
  output logic [1:0] lane_wr_mask, // active low lane masks
  output logic wr_port_sel_n, // write select, active low
  output logic rd_port_sel_n // read select, active low
);
  ////////////////////////////////////////////////////////////////////////////////
  // clock pins low and selects off from time zero, so reset sees no edge
  initial begin
    {k_clk, k_clk_n, c_clk, c_clk_n} = 4'h0;
    addr = '0;
    wr_data = '0;
    lane_wr_mask = 2'h3;
    wr_port_sel_n = 1'b1;
    rd_port_sel_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one pin pulse: qualifiers ride with the rising level and hold one cycle
  task automatic pulse(input logic [3:0] pins, input logic rs_n, input logic ws_n,
    input logic [bqs_pkg::ADDR_W-1:0] a, input logic [bqs_pkg::WORD_W-1:0] d,
    input logic [1:0] m);
    @(posedge core_clk);
    {k_clk, k_clk_n, c_clk, c_clk_n} <= pins;
    rd_port_sel_n <= rs_n;
    wr_port_sel_n <= ws_n;
    addr <= a;
    wr_data <= d;
    lane_wr_mask <= m;
    @(posedge core_clk);
    {k_clk, k_clk_n, c_clk, c_clk_n} <= 4'h0;
    rd_port_sel_n <= 1'b1;
    wr_port_sel_n <= 1'b1;
    // released lines flip so a stale value never passes for a good one
    addr <= ~a;
    wr_data <= ~d;
    lane_wr_mask <= ~m;
  endtask

  // data-only pulse: both selects stay off, so only an open write may use it
  task automatic beat(input logic [3:0] pins, input logic [bqs_pkg::ADDR_W-1:0] a,
    input logic [bqs_pkg::WORD_W-1:0] d, input logic [1:0] m);
    pulse(pins, 1'b1, 1'b1, a, d, m);
  endtask

  // bare clock pin pulse with selects off and lanes masked
  task automatic strobe(input logic [3:0] pins);
    pulse(pins, 1'b1, 1'b1, '0, '0, 2'h3);
  endtask

  // quiet cycles between pulses
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
endmodule // bqs_ctrl_model

// ==== verif/tb_bqs_sram.sv ====
// self-checking testbench for the burst-of-two split-port memory
`timescale 1ns/1ps
module tb_bqs_sram;
  localparam logic [3:0] K = 4'h8;
  localparam logic [3:0] KN = 4'h4;
  localparam logic [3:0] C = 4'h2;
  localparam logic [3:0] CN = 4'h1;
  typedef struct {
    logic rd; logic wr; logic sm;
    logic [18:0] ra; logic [18:0] wa;
    logic [17:0] d0; logic [17:0] d1; logic [1:0] m0; logic [1:0] m1;
  } bqs_row_t;
  logic core_clk, arst_n, single_clk_mode, k_clk, k_clk_n, c_clk, c_clk_n;
  logic wr_port_sel_n, rd_port_sel_n, rd_data_oe;
  logic [bqs_pkg::ADDR_W-1:0] addr;
  logic [bqs_pkg::WORD_W-1:0] wr_data, rd_data;
  logic [1:0] lane_wr_mask;
  logic [17:0] shd [logic [19:0]];
  bqs_row_t rows [5];
  int miscompares = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  bqs_sram i_bqs_sram (.core_clk(core_clk), .arst_n(arst_n), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .single_clk_mode(single_clk_mode),
    .addr(addr), .wr_data(wr_data), .lane_wr_mask_0(lane_wr_mask[0]),
    .lane_wr_mask_1(lane_wr_mask[1]), .wr_port_sel_n(wr_port_sel_n),
    .rd_port_sel_n(rd_port_sel_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe));
  bqs_ctrl_model i_bqs_ctrl_model (.core_clk(core_clk), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .addr(addr), .wr_data(wr_data),
    .lane_wr_mask(lane_wr_mask), .wr_port_sel_n(wr_port_sel_n),
    .rd_port_sel_n(rd_port_sel_n));

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // compare tasks, one per kind of result
  task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t rd_data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t rd_data_oe %b expected %b", $time, got, exp);
    end
  endtask

  // lane merge of a masked beat into the shadow copy
  function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] d,
    input logic [1:0] m);
    merge = old;
    if (!m[0]) merge[8:0] = d[8:0];
    if (!m[1]) merge[17:9] = d[17:9];
  endfunction
  function automatic logic [17:0] rdx(input logic [18:0] a, input logic b);
    return shd.exists({a, b}) ? shd[{a, b}] : 'x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one row: optional read taken on a k rise, optional write closed on k_n
  task automatic xfer(input bqs_row_t r);
    logic [17:0] e0, e1;
    // the read fetches at take time, so expectations come before the write lands
    e0 = rdx(r.ra, 1'b0);
    e1 = rdx(r.ra, 1'b1);
    @(posedge core_clk);
    single_clk_mode <= r.sm;
    i_bqs_ctrl_model.pulse(K, ~r.rd, ~r.wr, r.ra, r.d0, r.m0);
    i_bqs_ctrl_model.idle(1);
    if (r.wr) begin
      i_bqs_ctrl_model.beat(KN, r.wa, r.d1, r.m1);
      shd[{r.wa, 1'b0}] = merge(rdx(r.wa, 1'b0), r.d0, r.m0);
      shd[{r.wa, 1'b1}] = merge(rdx(r.wa, 1'b1), r.d1, r.m1);
    end
    if (r.rd) begin
      i_bqs_ctrl_model.idle(1);
      i_bqs_ctrl_model.strobe(r.sm ? K : C);
      i_bqs_ctrl_model.idle(3);
      #1;
      chk_word(rd_data, e0);
      chk_bit(rd_data_oe, 1'b1);
      i_bqs_ctrl_model.strobe(r.sm ? KN : CN);
      i_bqs_ctrl_model.idle(3);
      #1;
      chk_word(rd_data, e1);
      i_bqs_ctrl_model.strobe(K);
      i_bqs_ctrl_model.idle(3);
      #1;
      chk_bit(rd_data_oe, 1'b0);
    end
    i_bqs_ctrl_model.idle(2);
  endtask

  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, table rows, then the awkward cases
  initial begin
    arst_n = 1'b0;
    single_clk_mode = 1'b0;
    rows = '{
      '{1'b0, 1'b1, 1'b0, 19'h00000, 19'h00005, 18'h2a5a5, 18'h15a5a, 2'h0, 2'h0},
      '{1'b1, 1'b1, 1'b0, 19'h00005, 19'h7ffff, 18'h3ffff, 18'h00001, 2'h0, 2'h0},
      '{1'b1, 1'b0, 1'b1, 19'h7ffff, 19'h00000, 18'h00000, 18'h00000, 2'h3, 2'h3},
      '{1'b1, 1'b1, 1'b0, 19'h00005, 19'h00005, 18'h00000, 18'h3ffff, 2'h2, 2'h1},
      '{1'b1, 1'b0, 1'b0, 19'h00005, 19'h00000, 18'h00000, 18'h00000, 2'h3, 2'h3}};
    repeat (20) @(posedge core_clk);
    #1;
    chk_word(rd_data, bqs_pkg::RD_DATA_RST);
    chk_bit(rd_data_oe, 1'b0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(rows[i]);
      $display("test row %0d done", i);
    end
    // deselected write: data on both beats must not reach the array
    i_bqs_ctrl_model.beat(K, rows[0].wa, rows[1].d0, rows[0].m0);
    i_bqs_ctrl_model.idle(1);
    i_bqs_ctrl_model.beat(KN, rows[0].wa, rows[0].d1, rows[1].m1);
    xfer(rows[4]);
    $display("test write deselect done");
    // deselected read: an output rise must not turn the drivers on
    i_bqs_ctrl_model.beat(K, rows[4].ra, rows[4].d0, rows[4].m0);
    i_bqs_ctrl_model.idle(1);
    i_bqs_ctrl_model.strobe(C);
    i_bqs_ctrl_model.idle(3);
    #1;
    chk_bit(rd_data_oe, 1'b0);
    $display("test read deselect done");
    // second reset in mid-run clears the output register
    @(posedge core_clk);
    arst_n <= 1'b0;
    i_bqs_ctrl_model.idle(2);
    #1;
    chk_word(rd_data, bqs_pkg::RD_DATA_RST);
    chk_bit(rd_data_oe, 1'b0);
    // release again: the array keeps its contents, so a read must still match
    @(posedge core_clk);
    arst_n <= 1'b1;
    xfer(rows[4]);
    $display("test mid-run reset done");
    print_verdict();
  end

  // watchdog, far beyond the roughly 180 cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // tb_bqs_sram
